// ==== src/mbrfh_cfg.svh ====
// constants of the rtu frame handler
//
// Overview of operation
// - first byte of a frame is an 8-bit address, 0 to 247
// - address 0 is broadcast, 1 to 247 picks one station
// - the reply carries the address byte taken from the query
// - own address comes from station_number_setting and is compared
// - unsupported function (not 03,06,08,10,46) gets an error reply
// - a normal reply echoes the function byte unchanged
// - an error reply returns the function byte ORed with 80h
// - 03h reads holding registers, not allowed for broadcast
// - 06h writes one register, unicast or broadcast
// - 08h is a communication check, not allowed for broadcast
// - 10h writes consecutive registers, unicast or broadcast
// - 46h reports last access count, not allowed for broadcast
// - frames end in a 2-byte crc, low byte first
// - receiver recomputes the crc over the frame and compares
// - a crc mismatch marks the frame as erroneous
// - 3.5 character times of silence bound each frame
// - broadcasts are executed but never answered
// - no reply to frames with line, framing or crc errors
`ifndef MBRFH_CFG_SVH
`define MBRFH_CFG_SVH
`define MBRFH_CLK_HZ 40000000
`define MBRFH_BAUD 19200
`define MBRFH_CHAR_BITS 11
`define MBRFH_GAP_TENTHS 35
`define MBRFH_ADDR_BCAST 8'h00
`define MBRFH_ADDR_MAX 8'hF7
`define MBRFH_FC_RD_HOLD 8'h03
`define MBRFH_FC_WR_ONE 8'h06
`define MBRFH_FC_DIAG 8'h08
`define MBRFH_FC_WR_MULTI 8'h10
`define MBRFH_FC_ACC_LOG 8'h46
`define MBRFH_FC_ERR_BIT 8'h80
`define MBRFH_EXC_ILL_FUNC 8'h01
`define MBRFH_CRC_POLY 16'hA001
`define MBRFH_CRC_INIT 16'hFFFF
`define MBRFH_MIN_LEN 9'h004
`endif

// ==== src/mbrfh_frame_handler.sv ====
// rtu frame handler: receive, filter, check and reply
`timescale 1ns/1ps
`default_nettype none
`include "mbrfh_cfg.svh"
module mbrfh_frame_handler #(
  parameter int CHAR_CYC = (`MBRFH_CLK_HZ * `MBRFH_CHAR_BITS + `MBRFH_BAUD - 1) / `MBRFH_BAUD,
  parameter int SIL_CYC = (CHAR_CYC * `MBRFH_GAP_TENTHS + 9) / 10,
  parameter int GAP_W = 20,
  parameter int DEPTH = 256
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] station_number_setting_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_err_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic req_valid_o,
  output mbrfh_pkg::mbrfh_req_s req_o,
  input wire logic [7:0] pay_idx_i,
  output logic [7:0] pay_data_o,
  input wire mbrfh_pkg::mbrfh_resp_s resp_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_data_i,
  input wire logic resp_last_i,
  output logic resp_ready_o,
  output logic busy_o
);
  import mbrfh_pkg::*;

  // ----------------------------------------
  // crc and decode helpers
  // ----------------------------------------
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBRFH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc16

  function automatic logic fc_known(input logic [7:0] f);
    return f == `MBRFH_FC_RD_HOLD || f == `MBRFH_FC_WR_ONE || f == `MBRFH_FC_DIAG ||
           f == `MBRFH_FC_WR_MULTI || f == `MBRFH_FC_ACC_LOG;
  endfunction : fc_known

  function automatic logic fc_bcast_ok(input logic [7:0] f);
    return f == `MBRFH_FC_WR_ONE || f == `MBRFH_FC_WR_MULTI;
  endfunction : fc_bcast_ok

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  localparam logic [GAP_W-1:0] SIL_LAST = GAP_W'(SIL_CYC - 1);
  localparam logic [8:0] LEN_MAX = 9'(DEPTH);
  mbrfh_state_e st_q, st_d;
  logic [7:0] buf_q [DEPTH];
  logic [8:0] len_q;
  logic [GAP_W-1:0] gap_q;
  logic quiet_q, bad_q, bcast_q, exc_q, tx_full_q;
  logic [7:0] exc_code_q, tx_q;
  logic [15:0] crc_q;

  // ----------------------------------------
  // frame boundary and checks
  // ----------------------------------------
  wire logic gap_hit = !rx_valid_i && gap_q == SIL_LAST;
  wire logic in_rx = st_q == S_RX;
  wire logic fend = in_rx && gap_hit && len_q != 9'h000;
  wire logic [7:0] q_addr = buf_q[0];
  wire logic [7:0] q_func = buf_q[1];
  wire logic addr_bc = q_addr == `MBRFH_ADDR_BCAST;
  wire logic addr_me = q_addr == station_number_setting_i && q_addr <= `MBRFH_ADDR_MAX;
  wire logic crc_ok = crc_q == 16'h0000; // residue over data and crc
  wire logic frm_ok = !bad_q && crc_ok && len_q >= `MBRFH_MIN_LEN;
  wire logic take = fend && frm_ok && (addr_me || addr_bc);
  wire logic known = fc_known(q_func);
  wire logic bc_run = take && addr_bc && known && fc_bcast_ok(q_func);
  wire logic uc_run = take && !addr_bc && known;
  wire logic uc_err = take && !addr_bc && !known;
  wire logic slot = !tx_full_q || tx_ready_i;
  wire logic rx_byte = rx_valid_i && in_rx;

  // ----------------------------------------
  // reply sequencing
  // ----------------------------------------
  logic load;
  logic [7:0] load_byte;
  always_comb begin
    st_d = st_q;
    load = 1'b0;
    load_byte = 8'h00;
    unique case (st_q)
      S_RX: begin
        if (uc_run) begin
          st_d = S_WAIT;
        end else if (uc_err) begin
          st_d = S_ADDR;
        end
      end
      S_WAIT: begin
        if (resp_i.start) begin
          st_d = S_ADDR;
        end
      end
      S_ADDR: begin
        load = slot;
        load_byte = q_addr;
        if (slot) begin
          st_d = S_FUNC;
        end
      end
      S_FUNC: begin
        load = slot;
        load_byte = exc_q ? (q_func | `MBRFH_FC_ERR_BIT) : q_func;
        if (slot) begin
          st_d = exc_q ? S_EXC : S_DATA;
        end
      end
      S_EXC: begin
        load = slot;
        load_byte = exc_code_q;
        if (slot) begin
          st_d = S_CRCL;
        end
      end
      S_DATA: begin
        load = slot && resp_valid_i;
        load_byte = resp_data_i;
        if (load && resp_last_i) begin
          st_d = S_CRCL;
        end
      end
      S_CRCL: begin
        load = slot;
        load_byte = crc_q[7:0];
        if (slot) begin
          st_d = S_CRCH;
        end
      end
      S_CRCH: begin
        load = slot;
        load_byte = crc_q[15:8];
        if (slot) begin
          st_d = S_RX;
        end
      end
    endcase
  end
  assign resp_ready_o = st_q == S_DATA && slot;

  // state, flags and reply crc
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_RX;
      exc_q <= 1'b0;
      exc_code_q <= 8'h00;
      bcast_q <= 1'b0;
      crc_q <= `MBRFH_CRC_INIT;
    end else begin
      st_q <= st_d;
      if (fend) begin
        exc_q <= uc_err;
        exc_code_q <= `MBRFH_EXC_ILL_FUNC;
        bcast_q <= addr_bc;
        crc_q <= `MBRFH_CRC_INIT;
      end else if (st_q == S_WAIT && resp_i.start) begin
        exc_q <= resp_i.exc != 8'h00;
        exc_code_q <= resp_i.exc;
      end else if (gap_hit && in_rx) begin
        crc_q <= `MBRFH_CRC_INIT;
      end else if (rx_byte) begin
        crc_q <= crc16(crc_q, rx_data_i);
      end else if (load && st_q != S_CRCL && st_q != S_CRCH) begin
        crc_q <= crc16(crc_q, load_byte);
      end
    end
  end

  // receive bookkeeping: gap, length, error marks
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
      len_q <= 9'h000;
      quiet_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      if (rx_valid_i) begin
        gap_q <= '0;
      end else if (gap_q != SIL_LAST) begin
        gap_q <= gap_q + 1'b1;
      end
      if (gap_hit) begin
        quiet_q <= 1'b1;
        len_q <= 9'h000;
        bad_q <= 1'b0;
      end else if (rx_valid_i) begin
        quiet_q <= 1'b0;
        if (!in_rx || rx_err_i || len_q == LEN_MAX || (len_q == 9'h000 && !quiet_q)) begin
          bad_q <= 1'b1;
        end
        if (in_rx && len_q != LEN_MAX) begin
          len_q <= len_q + 1'b1;
        end
      end
    end
  end

  // frame store, no reset needed on the array
  always_ff @(posedge core_clk_i) begin
    if (rx_byte && len_q != LEN_MAX) begin
      buf_q[len_q[7:0]] <= rx_data_i;
    end
    pay_data_o <= buf_q[pay_idx_i];
  end

  // output byte register and request strobe
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_q <= 1'b0;
      tx_q <= 8'h00;
      req_valid_o <= 1'b0;
      req_o <= '0;
    end else begin
      if (load) begin
        tx_full_q <= 1'b1;
        tx_q <= load_byte;
      end else if (tx_ready_i) begin
        tx_full_q <= 1'b0;
      end
      req_valid_o <= uc_run || bc_run;
      if (uc_run || bc_run) begin
        req_o <= '{bcast: addr_bc, func: q_func, len: len_q};
      end
    end
  end
  assign tx_valid_o = tx_full_q;
  assign tx_data_o = tx_q;
  assign busy_o = !in_rx || tx_full_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_bcast_silent;
    @(posedge core_clk_i) disable iff (!rst_n)
    (fend && addr_bc) |=> (st_q == S_RX && !tx_full_q) [*8];
  endproperty
  a_bcast_silent: assert property (p_bcast_silent) else $error("reply to broadcast");
  property p_addr_echo;
    @(posedge core_clk_i) disable iff (!rst_n)
    (st_q == S_ADDR && slot) |=> (tx_q == q_addr && tx_valid_o && st_q == S_FUNC);
  endproperty
  a_addr_echo: assert property (p_addr_echo) else $error("address not echoed");
  property p_fc_echo;
    @(posedge core_clk_i) disable iff (!rst_n)
    (st_q == S_FUNC && slot && !exc_q) |=> (tx_q == q_func && st_q == S_DATA);
  endproperty
  a_fc_echo: assert property (p_fc_echo) else $error("function not echoed");
  property p_fc_err;
    @(posedge core_clk_i) disable iff (!rst_n)
    (st_q == S_FUNC && slot && exc_q) |=> (tx_q == (q_func | `MBRFH_FC_ERR_BIT) && st_q == S_EXC);
  endproperty
  a_fc_err: assert property (p_fc_err) else $error("error function byte wrong");
  property p_unsup;
    @(posedge core_clk_i) disable iff (!rst_n)
    (take && !addr_bc && !fc_known(q_func)) |=> (st_q == S_ADDR && exc_q && !req_valid_o);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported code not refused");
  property p_crc_drop;
    @(posedge core_clk_i) disable iff (!rst_n)
    (fend && !crc_ok) |=> (!req_valid_o && st_q == S_RX) ##1 !tx_full_q;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad crc frame used");
  property p_foreign;
    @(posedge core_clk_i) disable iff (!rst_n)
    (fend && !addr_bc && q_addr != station_number_setting_i) |=> !req_valid_o && st_q == S_RX;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign frame taken");
  property p_bc_forbid;
    @(posedge core_clk_i) disable iff (!rst_n)
    (fend && addr_bc && (q_func == `MBRFH_FC_RD_HOLD || q_func == `MBRFH_FC_DIAG ||
                         q_func == `MBRFH_FC_ACC_LOG)) |=> !req_valid_o;
  endproperty
  a_bc_forbid: assert property (p_bc_forbid) else $error("forbidden broadcast run");
  property p_crc_order;
    @(posedge core_clk_i) disable iff (!rst_n)
    (st_q == S_CRCL && slot) |=> (tx_q == $past(crc_q[7:0])) ##0 (st_q == S_CRCH);
  endproperty
  a_crc_order: assert property (p_crc_order) else $error("crc low byte not first");
  property p_gap_end;
    @(posedge core_clk_i) disable iff (!rst_n)
    req_valid_o |-> $past(gap_q) == SIL_LAST;
  endproperty
  a_gap_end: assert property (p_gap_end) else $error("frame ended without silence");
  c_uc_reply: cover property (@(posedge core_clk_i) disable iff (!rst_n) uc_run ##1 st_q == S_WAIT);
  c_bc_run: cover property (@(posedge core_clk_i) disable iff (!rst_n) bc_run);
  c_err_reply: cover property (@(posedge core_clk_i) disable iff (!rst_n) uc_err);
  c_crc_bad: cover property (@(posedge core_clk_i) disable iff (!rst_n) fend && !crc_ok);
endmodule : mbrfh_frame_handler
`default_nettype wire

// ==== src/mbrfh_pkg.sv ====
// types shared by the rtu frame handler
package mbrfh_pkg;
  typedef enum logic [2:0] {
    S_RX, S_WAIT, S_ADDR, S_FUNC, S_EXC, S_DATA, S_CRCL, S_CRCH
  } mbrfh_state_e;
  // request handed to the drive side for a frame that is accepted
  typedef struct packed {
    logic bcast;
    logic [7:0] func;
    logic [8:0] len;
  } mbrfh_req_s;
  // answer from the drive side; exc nonzero asks for an error reply
  typedef struct packed {
    logic start;
    logic [7:0] exc;
  } mbrfh_resp_s;
endpackage : mbrfh_pkg

// ==== verif/mbrfh_frame_handler_bench.sv ====
// self-checking bench of the rtu frame handler
`timescale 1ns/1ps
`default_nettype none
`define MBRFH_CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module mbrfh_frame_handler_bench;
  import mbrfh_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int SIL = 14;
  logic core_clk, rst_n, rx_valid, rx_err, tx_valid, tx_ready, req_valid, resp_valid;
  logic resp_last, resp_ready, busy;
  logic [7:0] st, rx_data, tx_data, pay_data, resp_data;
  mbrfh_req_s req, er;
  mbrfh_resp_s resp;
  logic [7:0] et;
  logic [7:0] pay_idx;
  mbrfh_req_s exp_req[$];
  logic [7:0] exp_tx[$];
  int num_errors = 0;
  int num_checks = 0;
  mbrfh_frame_handler #(.CHAR_CYC(4), .SIL_CYC(SIL)) u_mbrfh_frame_handler (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .station_number_setting_i(st),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_err_i(rx_err), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_ready_i(tx_ready), .req_valid_o(req_valid), .req_o(req),
    .pay_idx_i(pay_idx), .pay_data_o(pay_data), .resp_i(resp), .resp_valid_i(resp_valid),
    .resp_data_i(resp_data), .resp_last_i(resp_last), .resp_ready_o(resp_ready), .busy_o(busy));
  mbrfh_master_model u_mbrfh_master_model (.clk_i(core_clk), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_err_o(rx_err), .tx_ready_o(tx_ready));
  // reflected crc, low byte goes first on the line
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  // ----------------------------------------
  // output monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (req_valid === 1'b1) begin
      er = exp_req.size() ? exp_req.pop_front() : 'x;
      `MBRFH_CHK("request", er, req)
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      et = exp_tx.size() ? exp_tx.pop_front() : 'x;
      `MBRFH_CHK("reply byte", et, tx_data)
    end
  end
  // one query; flt 1 spoils the crc, flt 2 flags a line error
  task automatic run(input logic [7:0] adr, input logic [7:0] fc, input int flt,
                     input logic rq, input logic [7:0] exc);
    logic [7:0] f[$];
    logic [7:0] r[$];
    logic [15:0] c;
    logic [7:0] d;
    int n;
    f = {adr, fc, 8'($urandom), 8'($urandom)};
    c = crc16(f) ^ ((flt == 1) ? 16'h0001 : 16'h0000);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    d = 8'($urandom);
    if (rq) exp_req.push_back('{adr == 8'h00, fc, 9'h006});
    if (rq && adr != 8'h00) r = {adr, (exc != 8'h00) ? fc | 8'h80 : fc, (exc != 8'h00) ? exc : d};
    if (!(fc inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h46}) && adr == st && flt == 0)
      r = {adr, fc | 8'h80, 8'h01};
    if (r.size()) begin
      c = crc16(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
    end
    foreach (r[i]) exp_tx.push_back(r[i]);
    u_mbrfh_master_model.send(f, (flt == 2) ? 3 : -1);
    if (rq && adr != 8'h00) begin
      n = 0;
      do @(posedge core_clk); while (req_valid !== 1'b1 && ++n < 40);
      `MBRFH_CHK("silence cycles", SIL, n)
      `MBRFH_CHK("busy in reply", 1'b1, busy)
      #1;
      resp = '{1'b1, exc};
      resp_valid = (exc == 8'h00);
      resp_data = d;
      resp_last = 1'b1;
      @(posedge core_clk);
      #1;
      resp = '0;
      n = 0;
      while (resp_valid && resp_ready !== 1'b1 && ++n < 60) @(posedge core_clk);
      `MBRFH_CHK("data taken", 1'b1, !resp_valid || resp_ready === 1'b1)
      #1;
      resp_valid = 1'b0;
    end
    n = 0;
    while (exp_tx.size() && ++n < 200) @(posedge core_clk);
    `MBRFH_CHK("reply bytes left", 0, exp_tx.size())
    #1;
    pay_idx = 8'($urandom_range(0, 5));
    repeat (2) @(posedge core_clk);
    `MBRFH_CHK("stored byte", f[pay_idx], pay_data)
    `MBRFH_CHK("busy when idle", 1'b0, busy)
    repeat (SIL + 4) @(posedge core_clk);
  endtask : run
  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #(25 * 20000);
    num_errors++;
    give_verdict();
  end
  initial begin
    logic [7:0] codes[5];
    logic [4:0] bc_ok;
    codes = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
    bc_ok = 5'b01010; // only the two writes may be broadcast
    void'($urandom(86));
    rst_n = 1'b0;
    resp = '0;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    resp_last = 1'b0;
    pay_idx = 8'h00;
    st = 8'($urandom_range(1, 247));
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (SIL + 6) @(posedge core_clk);
    foreach (codes[i]) begin
      run(st, codes[i], 0, 1'b1, 8'h00);
      run(8'h00, codes[i], 0, bc_ok[i], 8'h00);
    end
    run(st, 8'h03, 0, 1'b1, 8'h02);
    run(st, 8'h05, 0, 1'b0, 8'h00);
    run(st, 8'hFF, 0, 1'b0, 8'h00);
    run((st == 8'hF7) ? 8'h01 : st + 8'h01, 8'h06, 0, 1'b0, 8'h00);
    run(st, 8'h03, 1, 1'b0, 8'h00);
    run(st, 8'h06, 2, 1'b0, 8'h00);
    run(st, 8'h06, 0, 1'b1, 8'h00);
    `MBRFH_CHK("notes left", 0, exp_req.size() + exp_tx.size())
    give_verdict();
  end
endmodule : mbrfh_frame_handler_bench
`default_nettype wire

// ==== verif/mbrfh_master_model.sv ====
// bus master model: sends query bytes and takes reply bytes with stalls
`timescale 1ns/1ps
`default_nettype none
module mbrfh_master_model (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_err_o,
  output logic tx_ready_o
);
  // ----------------------------------------
  // line driver
  // ----------------------------------------
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
    rx_err_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // the uart is busy one cycle in four on average, so replies stall
  always @(posedge clk_i) begin
    #1;
    tx_ready_o = ($urandom % 4) != 0;
  end
  // one byte every two cycles, well under the silence gap
  task automatic send(input logic [7:0] b[$], input int err_at);
    foreach (b[i]) begin // address, function, data, crc in order
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_data_o = b[i];
      rx_err_o = (i == err_at);
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b0;
      rx_data_o = ~b[i]; // stale data is not held once the strobe is gone
      rx_err_o = 1'b0;
    end
  endtask : send
endmodule : mbrfh_master_model
`default_nettype wire
